/* logic/pio_pkg.sv */
// constants, field layouts and carrier types of the programmable pin port
// assumes a 16-bit register file reached over classic wishbone, one word per register
package pio_pkg;

    // **********************************************************
    // geometry
    // **********************************************************
    localparam int PIN_COUNT = 48;
    localparam int REG_W     = 16;
    localparam int BANKS     = 3;
    localparam int ADDR_W    = 8;
    localparam int IRQ_PINS  = 8;
    localparam int ST_W      = 10;

    // **********************************************************
    // register byte offsets
    // **********************************************************
    localparam logic [7:0] OFS_FUNC   = 8'h00;
    localparam logic [7:0] OFS_DIR    = 8'h0c;
    localparam logic [7:0] OFS_PULL   = 8'h18;
    localparam logic [7:0] OFS_DOUT   = 8'h24;
    localparam logic [7:0] OFS_DIN    = 8'h30;
    localparam logic [7:0] OFS_CTRL   = 8'h3c;
    localparam logic [7:0] OFS_STATUS = 8'h40;
    localparam logic [7:0] OFS_MASK   = 8'h44;

    // **********************************************************
    // field positions
    // **********************************************************
    localparam int CTRL_PWD_EN     = 0;
    localparam int CTRL_EXT_IRQ_SEVEN_SHARE = 1;
    localparam int ST_PWD_INV      = 8;
    localparam int ST_PWD_TRUE     = 9;

    // **********************************************************
    // pin roles
    // **********************************************************
    localparam int PWD_PIN  = 6;
    localparam int EXT_IRQ_SEVEN_PIN = 7;
    localparam int TMR0_PIN = 27;
    localparam int TMR1_PIN = 0;
    localparam int IRQ_PIN [IRQ_PINS] = '{5, 15, 27, 29, 30, 33, 34, 35};
    localparam int SHARED_IRQ_CHANNEL = 14;

    // **********************************************************
    // reset values
    // **********************************************************
    localparam logic [PIN_COUNT-1:0] BUS_FUNC_PINS = 48'hff00_0000_0000;
    localparam logic [PIN_COUNT-1:0] FUNC_RST      = ~BUS_FUNC_PINS;
    localparam logic [PIN_COUNT-1:0] DIR_RST       = 48'hffff_ffff_ffff;
    localparam logic [PIN_COUNT-1:0] PULL_RST      = 48'hffff_ffff_ffff;
    localparam logic [PIN_COUNT-1:0] DOUT_RST      = 48'h0000_0000_0000;
    localparam logic [1:0]           CTRL_RST      = 2'h0;
    localparam logic [ST_W-1:0]      ST_RST        = 10'h000;

    // **********************************************************
    // carriers
    // **********************************************************
    typedef struct packed {
        logic pio_en;
        logic dir_in;
        logic pull_up;
        logic dout;
    } pin_cfg_t;

    typedef struct packed {
        logic out;
        logic oe;
        logic pu_en;
        logic pd_en;
    } pad_drv_t;

    typedef struct packed {
        logic tmr0_level;
        logic tmr1_level;
        logic tmr0_tick;
        logic tmr1_tick;
    } timer_feed_t;

endpackage : pio_pkg

/* logic/pin_sync.sv */
// three-flop input synchroniser with agreement filter, one lane per pin
// assumes inputs are asynchronous to clk_i
`timescale 1ns/100ps
`default_nettype none

module pin_sync
#(
    parameter int WIDTH = 48,
    parameter logic [WIDTH-1:0] INIT = '1
)
(
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // pins and result
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    // **********************************************************
    // per-lane chain
    // **********************************************************
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_lane
            logic s1;
            logic s2;
            logic s3;
            wire  agree = (s2 == s3);
            // first stage feeds only the second: metastability guard
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    s1        <= INIT[g];
                    s2        <= INIT[g];
                    s3        <= INIT[g];
                    sync_o[g] <= INIT[g];
                end
                else
                begin
                    s1 <= async_i[g];
                    s2 <= s1;
                    s3 <= s2;
                    if (agree)
                        sync_o[g] <= s3;
                end
            end
        end
    endgenerate

endmodule // pin_sync

`default_nettype wire

/* logic/pin_cell.sv */
// pad steering for one shared pin: programmable i/o or alternate function
// assumes the pad ring resolves out/oe and applies the weak pull enables
`timescale 1ns/100ps
`default_nettype none

module pin_cell
    import pio_pkg::*;
(
    // configuration
    input  wire pio_pkg::pin_cfg_t cfg_i,
    // alternate function drive
    input  wire logic              alt_out_i,
    input  wire logic              alt_oe_i,
    // pad
    output pio_pkg::pad_drv_t      drv_o
);

    // **********************************************************
    // steering
    // **********************************************************
    wire pio_in  = cfg_i.pio_en & cfg_i.dir_in;
    wire pio_out = cfg_i.pio_en & ~cfg_i.dir_in;

    // pulls only act on pio inputs so an output never fights its own pull
    assign drv_o.out   = cfg_i.pio_en ? cfg_i.dout : alt_out_i;
    assign drv_o.oe    = cfg_i.pio_en ? pio_out : alt_oe_i;
    assign drv_o.pu_en = pio_in & cfg_i.pull_up;
    assign drv_o.pd_en = pio_in & ~cfg_i.pull_up;

endmodule // pin_cell

`default_nettype wire

/* logic/pio_port.sv */
// programmable pin port with pulse-width demodulator routing and pin interrupts
// assumes a classic wishbone master on clk_i, pad ring outside, timers and
// interrupt controller consuming the level and tick outputs
//
// Function
// - per pin function, direction, pull select
// - reset leaves most pins pio inputs pulled up
// - eight pins interrupt on shared channel 14
// - bus control pins reset to bus function
// - demod true drives timer 0, int 8
// - demod inverted drives timer 1, extra irq
// - timer pins free as pio, else ignored
// - extra irq uses ext int 7 channel
// - timer inputs clock or control their timers
// - timer inputs synchronised, count each rising edge
// - timer input held high when pin is pio
//
// Implementation choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none

module pio_port
    import pio_pkg::*;
#(
    parameter int                    PINS      = pio_pkg::PIN_COUNT,
    parameter logic [PIN_COUNT-1:0]  FUNC_INIT = pio_pkg::FUNC_RST
)
(
    // clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    // wishbone slave
    input  wire logic                        cyc_i,
    input  wire logic                        stb_i,
    input  wire logic                        we_i,
    input  wire logic [pio_pkg::ADDR_W-1:0]  adr_i,
    input  wire logic [1:0]                  sel_i,
    input  wire logic [pio_pkg::REG_W-1:0]   dat_i,
    output logic      [pio_pkg::REG_W-1:0]   dat_o,
    output logic                             ack_o,
    // pads
    input  wire logic [PINS-1:0]             pad_in_i,
    output logic      [PINS-1:0]             pad_out_o,
    output logic      [PINS-1:0]             pad_oe_o,
    output logic      [PINS-1:0]             pad_pu_o,
    output logic      [PINS-1:0]             pad_pd_o,
    // alternate functions
    input  wire logic [PINS-1:0]             alt_out_i,
    input  wire logic [PINS-1:0]             alt_oe_i,
    output logic      [PINS-1:0]             alt_in_o,
    // timers
    output pio_pkg::timer_feed_t             timer_o,
    // interrupt controller
    output logic                             ext_irq_eight_o,
    output logic                             ext_irq_seven_o,
    output logic                             shared_irq_o,
    output logic                             irq_o
);

    // **********************************************************
    // registers
    // **********************************************************
    logic [PINS-1:0]  pio_en;
    logic [PINS-1:0]  dir_in;
    logic [PINS-1:0]  pull_up;
    logic [PINS-1:0]  dout;
    logic [1:0]       ctrl;
    logic [ST_W-1:0]  status;
    logic [ST_W-1:0]  mask;
    logic [PINS-1:0]  pin_sync_q;
    logic [PINS-1:0]  pin_prev;
    logic             pwd_prev;
    logic             tmr0_prev;
    logic             tmr1_prev;

    // **********************************************************
    // bus decode
    // **********************************************************
    wire              req      = cyc_i & stb_i & ~ack_o;
    wire              wr       = req & we_i;
    wire [7:0]        adr      = adr_i;
    wire [REG_W-1:0]  bmask    = {{8{sel_i[1]}}, {8{sel_i[0]}}};
    wire              hit_ctrl = (adr == OFS_CTRL);
    wire              hit_st   = (adr == OFS_STATUS);
    wire              hit_mask = (adr == OFS_MASK);

    logic [BANKS-1:0] hit_func;
    logic [BANKS-1:0] hit_dir;
    logic [BANKS-1:0] hit_pull;
    logic [BANKS-1:0] hit_dout;
    logic [BANKS-1:0] hit_din;

    genvar b;
    generate
        for (b = 0; b < BANKS; b++)
        begin : g_dec
            localparam logic [7:0] STEP = 8'(4 * b);
            assign hit_func[b] = (adr == OFS_FUNC + STEP);
            assign hit_dir[b]  = (adr == OFS_DIR  + STEP);
            assign hit_pull[b] = (adr == OFS_PULL + STEP);
            assign hit_dout[b] = (adr == OFS_DOUT + STEP);
            assign hit_din[b]  = (adr == OFS_DIN  + STEP);
        end
    endgenerate

    // **********************************************************
    // demodulator and timer routing
    // **********************************************************
    wire pwd_en     = ctrl[CTRL_PWD_EN];
    wire ext_irq_seven_share = ctrl[CTRL_EXT_IRQ_SEVEN_SHARE];
    // synchronised pin stands in for the schmitt path
    wire pwd_level  = pin_sync_q[PWD_PIN];

    // demod mode ignores the timer pins; pio use of a pin holds it high
    wire tmr0_pin   = pio_en[TMR0_PIN] ? 1'b1 : pin_sync_q[TMR0_PIN];
    wire tmr1_pin   = pio_en[TMR1_PIN] ? 1'b1 : pin_sync_q[TMR1_PIN];
    wire tmr0_level = pwd_en ? pwd_level : tmr0_pin;
    wire tmr1_level = pwd_en ? ~pwd_level : tmr1_pin;

    assign timer_o.tmr0_level = tmr0_level;
    assign timer_o.tmr1_level = tmr1_level;
    assign timer_o.tmr0_tick  = tmr0_level & ~tmr0_prev;
    assign timer_o.tmr1_tick  = tmr1_level & ~tmr1_prev;

    // **********************************************************
    // interrupt events
    // **********************************************************
    wire              pwd_rise = pwd_en & pwd_level & ~pwd_prev;
    wire              pwd_fall = pwd_en & ~pwd_level & pwd_prev;
    logic [ST_W-1:0]  event_set;

    genvar k;
    generate
        for (k = 0; k < IRQ_PINS; k++)
        begin : g_evt
            // only a pin in pio input mode may raise its interrupt
            assign event_set[k] = pio_en[IRQ_PIN[k]] & dir_in[IRQ_PIN[k]]
                                & pin_sync_q[IRQ_PIN[k]] & ~pin_prev[IRQ_PIN[k]];
        end
    endgenerate
    assign event_set[ST_PWD_INV]  = pwd_fall;
    assign event_set[ST_PWD_TRUE] = pwd_rise;

    wire [ST_W-1:0] pending   = status & mask;
    wire            pin_irq   = |pending[IRQ_PINS-1:0];
    wire            ext_irq_seven_pin  = ~pio_en[EXT_IRQ_SEVEN_PIN] & pin_sync_q[EXT_IRQ_SEVEN_PIN];
    wire            ext_irq_eight_pin  = ~pio_en[PWD_PIN] & pin_sync_q[PWD_PIN];

    // int 7 pin only reaches the shared channel when moved there
    assign shared_irq_o    = pin_irq | (ext_irq_seven_share & ext_irq_seven_pin);
    assign ext_irq_seven_o = pwd_en ? pending[ST_PWD_INV]
                                    : (~ext_irq_seven_share & ext_irq_seven_pin);
    assign ext_irq_eight_o = pwd_en ? pwd_level : ext_irq_eight_pin;
    assign irq_o           = |pending;

    // **********************************************************
    // pads
    // **********************************************************
    genvar p;
    generate
        for (p = 0; p < PINS; p++)
        begin : g_pin
            pin_cfg_t cfg;
            pad_drv_t drv;
            assign cfg.pio_en  = pio_en[p];
            assign cfg.dir_in  = dir_in[p];
            assign cfg.pull_up = pull_up[p];
            assign cfg.dout    = dout[p];
            pin_cell u_cell
            (
                .cfg_i     (cfg),
                .alt_out_i (alt_out_i[p]),
                .alt_oe_i  (alt_oe_i[p]),
                .drv_o     (drv)
            );
            assign pad_out_o[p] = drv.out;
            assign pad_oe_o[p]  = drv.oe;
            assign pad_pu_o[p]  = drv.pu_en;
            assign pad_pd_o[p]  = drv.pd_en;
        end
    endgenerate

    pin_sync
    #(
        .WIDTH (PINS),
        .INIT  ({PINS{1'b1}})
    )
    u_sync
    (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (pad_in_i),
        .sync_o  (pin_sync_q)
    );

    assign alt_in_o = pin_sync_q;

    // **********************************************************
    // read mux
    // **********************************************************
    logic [REG_W-1:0] rd_data;

    always_comb
    begin
        rd_data = 16'h0000;
        for (int i = 0; i < BANKS; i++)
        begin
            if (hit_func[i])
                rd_data = pio_en[i*REG_W +: REG_W];
            if (hit_dir[i])
                rd_data = dir_in[i*REG_W +: REG_W];
            if (hit_pull[i])
                rd_data = pull_up[i*REG_W +: REG_W];
            if (hit_dout[i])
                rd_data = dout[i*REG_W +: REG_W];
            if (hit_din[i])
                rd_data = pin_sync_q[i*REG_W +: REG_W];
        end
        if (hit_ctrl)
            rd_data = {14'h0000, ctrl};
        if (hit_st)
            rd_data = {6'h00, status};
        if (hit_mask)
            rd_data = {6'h00, mask};
    end

    // **********************************************************
    // next values
    // **********************************************************
    logic [PINS-1:0] next_pio_en;
    logic [PINS-1:0] next_dir_in;
    logic [PINS-1:0] next_pull_up;
    logic [PINS-1:0] next_dout;

    generate
        for (b = 0; b < BANKS; b++)
        begin : g_wr
            wire [REG_W-1:0] wm = bmask & {REG_W{wr}};
            assign next_pio_en[b*REG_W +: REG_W] = hit_func[b]
                ? ((pio_en[b*REG_W +: REG_W] & ~wm) | (dat_i & wm))
                : pio_en[b*REG_W +: REG_W];
            assign next_dir_in[b*REG_W +: REG_W] = hit_dir[b]
                ? ((dir_in[b*REG_W +: REG_W] & ~wm) | (dat_i & wm))
                : dir_in[b*REG_W +: REG_W];
            assign next_pull_up[b*REG_W +: REG_W] = hit_pull[b]
                ? ((pull_up[b*REG_W +: REG_W] & ~wm) | (dat_i & wm))
                : pull_up[b*REG_W +: REG_W];
            assign next_dout[b*REG_W +: REG_W] = hit_dout[b]
                ? ((dout[b*REG_W +: REG_W] & ~wm) | (dat_i & wm))
                : dout[b*REG_W +: REG_W];
        end
    endgenerate

    wire [ST_W-1:0] wr_lo     = dat_i[ST_W-1:0] & bmask[ST_W-1:0] & {ST_W{wr}};
    wire [ST_W-1:0] st_clear  = hit_st ? wr_lo : '0;
    // a new event beats a write-one clear in the same cycle
    wire [ST_W-1:0] next_status = (status & ~st_clear) | event_set;
    wire [ST_W-1:0] next_mask   = (wr & hit_mask)
                                ? ((mask & ~bmask[ST_W-1:0]) | (dat_i[ST_W-1:0] & bmask[ST_W-1:0]))
                                : mask;
    wire [1:0]      next_ctrl   = (wr & hit_ctrl & sel_i[0]) ? dat_i[1:0] : ctrl;

    // **********************************************************
    // state
    // **********************************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pio_en  <= FUNC_INIT;
            dir_in  <= DIR_RST;
            pull_up <= PULL_RST;
            dout    <= DOUT_RST;
            ctrl    <= CTRL_RST;
            status  <= ST_RST;
            mask    <= ST_RST;
        end
        else
        begin
            pio_en  <= next_pio_en;
            dir_in  <= next_dir_in;
            pull_up <= next_pull_up;
            dout    <= next_dout;
            ctrl    <= next_ctrl;
            status  <= next_status;
            mask    <= next_mask;
        end
    end

    // edge history; reset high so no false edge fires after release
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_prev  <= '1;
            pwd_prev  <= 1'b1;
            tmr0_prev <= 1'b1;
            tmr1_prev <= 1'b1;
        end
        else
        begin
            pin_prev  <= pin_sync_q;
            pwd_prev  <= pwd_level;
            tmr0_prev <= tmr0_level;
            tmr1_prev <= tmr1_level;
        end
    end

    // single wait state answer; unmapped reads return zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 16'h0000;
        end
        else
        begin
            ack_o <= req;
            dat_o <= req ? rd_data : dat_o;
        end
    end

endmodule // pio_port

`default_nettype wire

/* dv/pio_port_properties.sv */
// concurrent checks on the ports of pio_port, bound into it
// assumes classic wishbone on clk_i and synchronous active high rst_i
`timescale 1ns/100ps
`default_nettype none

module pio_port_properties
    import pio_pkg::*;
#(
    parameter int                   PINS      = pio_pkg::PIN_COUNT,
    parameter logic [PIN_COUNT-1:0] FUNC_INIT = pio_pkg::FUNC_RST
)
(
    // clock, reset, bus
    input wire logic                       clk_i,
    input wire logic                       rst_i,
    input wire logic                       cyc_i,
    input wire logic                       stb_i,
    input wire logic                       we_i,
    input wire logic [pio_pkg::ADDR_W-1:0] adr_i,
    input wire logic [1:0]                 sel_i,
    input wire logic [pio_pkg::REG_W-1:0]  dat_i,
    input wire logic                       ack_o,
    // pads, timers, interrupts
    input wire logic [PINS-1:0]            pad_in_i,
    input wire logic [PINS-1:0]            pad_oe_o,
    input wire logic [PINS-1:0]            pad_pu_o,
    input wire logic [PINS-1:0]            pad_pd_o,
    input wire logic [PINS-1:0]            alt_oe_i,
    input wire logic [PINS-1:0]            alt_in_o,
    input wire pio_pkg::timer_feed_t       timer_o,
    input wire logic                       ext_irq_eight_o
);
    // ********
    // demod mode shadow, taken from bus writes
    // ********
    logic pwd_mode;
    wire  ctrl_wr = cyc_i & stb_i & ~ack_o & we_i & sel_i[0] & (adr_i == OFS_CTRL);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pwd_mode <= 1'b0;
        else if (ctrl_wr)
            pwd_mode <= dat_i[CTRL_PWD_EN];
    end

    default clocking cb @(posedge clk_i);
    endclocking

    // ********
    // properties
    // ********
    a_ack_latency: assert property (disable iff (rst_i)
        cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack after request");
    a_ack_single: assert property (disable iff (rst_i)
        ack_o |=> !ack_o) else $error("ack longer than one cycle");
    a_pull_exclusive: assert property (disable iff (rst_i)
        ((pad_pu_o & pad_pd_o) | (pad_oe_o & (pad_pu_o | pad_pd_o))) == '0)
        else $error("pull and drive overlap");
    // no disable here: the reset values themselves are the point
    a_reset_pull: assert property (rst_i ##1 rst_i |->
        pad_pu_o == FUNC_INIT && pad_pd_o == '0) else $error("reset pull wrong");
    a_reset_busfn: assert property (rst_i ##1 rst_i |->
        pad_oe_o == (alt_oe_i & ~FUNC_INIT)) else $error("reset drive wrong");
    a_demod_true: assert property (disable iff (rst_i)
        pwd_mode |-> timer_o.tmr0_level == alt_in_o[PWD_PIN] &&
        ext_irq_eight_o == alt_in_o[PWD_PIN]) else $error("demod true path");
    a_demod_inv: assert property (disable iff (rst_i)
        pwd_mode |-> timer_o.tmr1_level == !alt_in_o[PWD_PIN]) else $error("demod inverse");
    a_tick_edge: assert property (disable iff (rst_i)
        timer_o.tmr0_tick == (timer_o.tmr0_level && !$past(timer_o.tmr0_level)) &&
        timer_o.tmr1_tick == (timer_o.tmr1_level && !$past(timer_o.tmr1_level)))
        else $error("tick not on rising level");
    // a change only passes once two stages agree on the new pad level
    a_sync_stages: assert property (disable iff (rst_i)
        ((alt_in_o ^ $past(alt_in_o)) & ((alt_in_o ^ $past(pad_in_i, 3)) |
        (alt_in_o ^ $past(pad_in_i, 4)))) == '0) else $error("input not synced");

endmodule // pio_port_properties

bind pio_port pio_port_properties #(.PINS(PINS), .FUNC_INIT(FUNC_INIT)) u_props (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .ack_o,
    .pad_in_i, .pad_oe_o, .pad_pu_o, .pad_pd_o, .alt_oe_i, .alt_in_o,
    .timer_o, .ext_irq_eight_o
);

`default_nettype wire

/* dv/pad_board.sv */
// board side of the shared pins: drivers, weak pulls, floating lines
// assumes the bench steers ext_en_i and ext_val_i on clk_i
`timescale 1ns/100ps
`default_nettype none

module pad_board
(
    // clock
    input  wire logic        clk_i,
    // port pad side
    input  wire logic [47:0] pad_out_i,
    input  wire logic [47:0] pad_oe_i,
    input  wire logic [47:0] pad_pu_i,
    input  wire logic [47:0] pad_pd_i,
    // board drivers
    input  wire logic [47:0] ext_en_i,
    input  wire logic [47:0] ext_val_i,
    output logic      [47:0] pad_o
);
    logic [47:0] last = '0;

    always_ff @(posedge clk_i)
        last <= pad_o;

    // floating lines toggle so no stale level looks valid
    always_comb
        for (int i = 0; i < 48; i++)
            pad_o[i] = pad_oe_i[i] ? pad_out_i[i] : ext_en_i[i] ? ext_val_i[i] :
                       pad_pu_i[i] ? 1'b1 : pad_pd_i[i] ? 1'b0 : ~last[i];

endmodule // pad_board

`default_nettype wire

/* dv/testbench.sv */
// directed tests of pio_port over its wishbone registers and pads
// assumes pad_board on the pins and the bound property checker
`timescale 1ns/100ps
`default_nettype none

`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end

module testbench;
    import pio_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0] adr_i = '0;
    logic [1:0] sel_i = '0;
    logic [15:0] dat_i = '0, dat_o, rdv;
    logic ack_o, ext_irq_eight_o, ext_irq_seven_o, shared_irq_o, irq_o;
    logic [47:0] pad_in_i, pad_out_o, pad_oe_o, pad_pu_o, pad_pd_o, alt_in_o, irqv;
    logic [47:0] alt_out_i = 48'ha500_0020_0000, alt_oe_i = 48'hff00_0020_0000;
    logic [47:0] ext_en = '0, ext_val = '0;
    timer_feed_t timer_o;
    int num_errors = 0, checks_done = 0, t0 = 0, t1 = 0, s0, s1;

    always #25 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        t0 += int'(timer_o.tmr0_tick);
        t1 += int'(timer_o.tmr1_tick);
    end

    pio_port dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
        .ack_o, .pad_in_i, .pad_out_o, .pad_oe_o, .pad_pu_o, .pad_pd_o, .alt_out_i,
        .alt_oe_i, .alt_in_o, .timer_o, .ext_irq_eight_o, .ext_irq_seven_o,
        .shared_irq_o, .irq_o);
    pad_board board (.clk_i, .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o),
        .pad_pu_i(pad_pu_o), .pad_pd_i(pad_pd_o), .ext_en_i(ext_en),
        .ext_val_i(ext_val), .pad_o(pad_in_i));

    // ********
    // bus and helpers
    // ********
    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 2'h3;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_o !== 1'b1 && n < 50);
        if (n >= 50)
            `CHK(ack_o, 1'b1)
        rdv = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        wb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        wb(1'b0, a, 16'h0000);
        `CHK(rdv, e)
    endtask

    task automatic pause(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ********
    // tests
    // ********
    initial
    begin
        irqv = '0;
        for (int i = 0; i < IRQ_PINS; i++)
            irqv[IRQ_PIN[i]] = 1'b1;
        pause(3);
        rst_i <= 1'b0;
        pause(1);
        for (int k = 0; k < 3; k++)
        begin
            rd(OFS_FUNC + 8'(4 * k), FUNC_RST[16 * k +: 16]);
            rd(OFS_DIR + 8'(4 * k), 16'hffff);
            rd(OFS_PULL + 8'(4 * k), 16'hffff);
            rd(OFS_DOUT + 8'(4 * k), 16'h0000);
        end
        rd(OFS_CTRL, 16'h0000);
        rd(OFS_STATUS, 16'h0000);
        `CHK(pad_pu_o, FUNC_RST)
        `CHK(pad_out_o[47:40], 8'ha5)
        wr(8'h80, 16'hffff);
        rd(8'h80, 16'h0000);
        $display("reset defaults done");
        wr(OFS_DIR + 8'h04, 16'hfff0);
        wr(OFS_DOUT + 8'h04, 16'h000a);
        wr(OFS_PULL + 8'h04, 16'hffef);
        wr(OFS_FUNC + 8'h04, 16'hffdf);
        ext_en[22] <= 1'b1;
        pause(8);
        `CHK(pad_oe_o[21:16], 6'h2f)
        `CHK(pad_out_o[21:16], 6'h2a)
        `CHK({pad_pd_o[21:16], pad_pu_o[21:16]}, 12'h400)
        `CHK(alt_in_o[22], 1'b0)
        wr(OFS_DIN + 8'h04, 16'h0000);
        rd(OFS_DIN + 8'h04, 16'hffaa);
        $display("pin attributes done");
        ext_en <= ext_en | irqv;
        pause(8);
        rd(OFS_STATUS, 16'h0000);
        ext_val <= irqv;
        pause(8);
        rd(OFS_STATUS, 16'h00ff);
        `CHK({irq_o, shared_irq_o}, 2'b00)
        wr(OFS_MASK, 16'h0001);
        `CHK({irq_o, shared_irq_o}, 2'b11)
        wr(OFS_STATUS, 16'h0001);
        `CHK(irq_o, 1'b0)
        rd(OFS_STATUS, 16'h00fe);
        wr(OFS_STATUS, 16'h00fe);
        $display("pin interrupts done");
        wr(OFS_MASK, 16'h0300);
        wr(OFS_CTRL, 16'h0001);
        s0 = t0;
        s1 = t1;
        ext_en[6] <= 1'b1;
        ext_val[27] <= 1'b0;
        ext_en[0] <= 1'b1;
        ext_val[6] <= 1'b0;
        pause(8);
        `CHK({timer_o.tmr0_level, timer_o.tmr1_level, ext_irq_eight_o}, 3'b010)
        for (int i = 0; i < 3; i++)
        begin
            ext_val[6] <= 1'b1;
            pause(8);
            `CHK({timer_o.tmr0_level, timer_o.tmr1_level, ext_irq_eight_o}, 3'b101)
            ext_val[6] <= 1'b0;
            pause(8);
        end
        `CHK(t0 - s0, 3)
        `CHK(t1 - s1, 4)
        rd(OFS_STATUS, 16'h0300);
        `CHK(ext_irq_seven_o, 1'b1)
        wr(OFS_STATUS, 16'h0100);
        `CHK(ext_irq_seven_o, 1'b0)
        wr(OFS_CTRL, 16'h0003);
        ext_en[7] <= 1'b1;
        ext_val[7] <= 1'b1;
        wr(OFS_FUNC, 16'hff7f);
        pause(8);
        `CHK({shared_irq_o, ext_irq_seven_o}, 2'b10)
        $display("demodulator done");
        wr(OFS_CTRL, 16'h0000);
        pause(8);
        `CHK({timer_o.tmr0_level, timer_o.tmr1_level}, 2'b11)
        wr(OFS_FUNC + 8'h04, 16'hf7df);
        pause(8);
        `CHK(timer_o.tmr0_level, 1'b0)
        s0 = t0;
        ext_val[27] <= 1'b1;
        pause(8);
        `CHK(t0 - s0, 1)
        rst_i <= 1'b1;
        pause(3);
        rst_i <= 1'b0;
        pause(1);
        `CHK(pad_pu_o, FUNC_RST)
        $display("timer inputs and second reset done");
        finish_test();
    end

    initial
    begin
        #(50 * 20000);
        num_errors++;
        finish_test();
    end

endmodule // testbench

`default_nettype wire
